// ### rtl/cisl_irq_driver.sv
// interrupt line driver with polarity and output enable
`timescale 1ns/10ps
`default_nettype none
module cisl_irq_driver (
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	input wire logic req_in,
	input wire logic polarity_in,
	input wire logic enable_in,
	output logic line_out,
	output logic line_oe_out
);
	typedef struct packed {
		logic line;
		logic oe;
	} cisl_drv_state_t;

	cisl_drv_state_t s;
	cisl_drv_state_t next_s;

	always_comb begin
		next_s = s;
		next_s.line = polarity_in ? req_in : ~req_in; // R18
		next_s.oe = enable_in; // R19
	end

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign line_out = s.line;
	assign line_oe_out = s.oe;

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (sys_rst_in);

	a_line_polarity: assert property ( // R18
		##1 !$past(sys_rst_in) |-> line_out == ($past(polarity_in) ? $past(req_in) : !$past(req_in)))
		else $error("interrupt line level does not follow polarity");
	a_driver_enable: assert property ( // R19
		##1 !$past(sys_rst_in) |-> line_oe_out == $past(enable_in))
		else $error("interrupt driver enable does not follow setting");
endmodule
`default_nettype wire

// ### rtl/cisl_irq_status.sv
// interrupt status, mask, clear and disable registers of the codec
`timescale 1ns/10ps
`default_nettype none
module cisl_irq_status (
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	input wire cisl_pkg::cisl_evt_t events_in,
	input wire cisl_pkg::cisl_reg_req_t reg_req_in,
	output logic [15:0] reg_rdata_out,
	output logic irq_line_out,
	output logic irq_line_oe_out
);
	typedef struct packed {
		logic [15:0] mask;
		logic [15:0] disable_ctrl;
		logic short_circuit_shutdown_flag;
		logic impedance_measure_flag;
		logic key_release_flag;
		logic key_press_flag;
		logic clock_loss_flag;
		logic mic_detect_flag;
		logic [1:0] jack_eject_state;
		logic [1:0] jack_insert_state;
		logic [15:0] rdata;
	} cisl_state_t;

	cisl_state_t s;
	cisl_state_t next_s;
	logic [15:0] clr;
	logic [15:0] status_word;
	logic [15:0] live_bits;
	logic irq_req;
	logic set_short;
	logic set_imp;
	logic set_keyr;
	logic set_keyp;
	logic set_clk;
	logic set_mic;
	logic set_ins;
	logic set_ej;

	// new event wins over cancel, cancel wins over a software clear
	function automatic logic [1:0] jack_next(input logic [1:0] cur, input logic own_evt,
			input logic other_evt, input logic clr_hit);
		logic [1:0] r;
		r = cur;
		if (own_evt) begin
			r = cisl_pkg::JACK_SEEN;
		end else if (other_evt && cur == cisl_pkg::JACK_SEEN) begin
			r = cisl_pkg::JACK_CANCEL;
		end else if (clr_hit) begin
			r = cisl_pkg::JACK_CLEAR;
		end
		return r;
	endfunction

	function automatic logic reg_hit(input cisl_pkg::cisl_reg_req_t q, input logic [7:0] a);
		return q.wr && q.addr == a;
	endfunction

	// the lower bit of each jack pair gates both code bits
	function automatic logic [15:0] pair_gate(input logic [15:0] w);
		logic [15:0] r;
		r = w;
		r[cisl_pkg::BIT_JACK_INS_HI] = w[cisl_pkg::BIT_JACK_INS_LO];
		r[cisl_pkg::BIT_JACK_EJ_HI] = w[cisl_pkg::BIT_JACK_EJ_LO];
		return r;
	endfunction

	always_comb begin
		status_word = '0;
		status_word[cisl_pkg::BIT_JACK_INS_HI:cisl_pkg::BIT_JACK_INS_LO] = s.jack_insert_state;
		status_word[cisl_pkg::BIT_JACK_EJ_HI:cisl_pkg::BIT_JACK_EJ_LO] = s.jack_eject_state;
		status_word[cisl_pkg::BIT_MIC] = s.mic_detect_flag; // R10
		status_word[cisl_pkg::BIT_CLK_LOSS] = s.clock_loss_flag; // R9
		status_word[cisl_pkg::BIT_KEY_PRESS] = s.key_press_flag; // R8
		status_word[cisl_pkg::BIT_KEY_REL] = s.key_release_flag; // R8
		status_word[cisl_pkg::BIT_IMPEDANCE] = s.impedance_measure_flag; // R7
		status_word[cisl_pkg::BIT_SHORT] = s.short_circuit_shutdown_flag; // R6
	end

	// pending, enabled and unmasked sources drive the request
	assign live_bits = status_word & ~pair_gate(s.mask) & ~pair_gate(s.disable_ctrl)
		& cisl_pkg::SOURCE_BITS; // R1 R2 R3 R4 R5
	assign irq_req = |live_bits; // R20

	// a disabled source never raises its flag
	assign set_short = events_in.short_circuit && !s.disable_ctrl[cisl_pkg::BIT_SHORT]; // R16
	assign set_imp = events_in.impedance && !s.disable_ctrl[cisl_pkg::BIT_IMPEDANCE]; // R17
	assign set_keyr = events_in.key_release && !s.disable_ctrl[cisl_pkg::BIT_KEY_REL];
	assign set_keyp = events_in.key_press && !s.disable_ctrl[cisl_pkg::BIT_KEY_PRESS];
	assign set_clk = events_in.clock_loss && !s.disable_ctrl[cisl_pkg::BIT_CLK_LOSS];
	assign set_mic = events_in.mic_detect && !s.disable_ctrl[cisl_pkg::BIT_MIC];
	assign set_ins = events_in.jack_insert && !s.disable_ctrl[cisl_pkg::BIT_JACK_INS_LO];
	assign set_ej = events_in.jack_eject && !s.disable_ctrl[cisl_pkg::BIT_JACK_EJ_LO];

	assign clr = reg_hit(reg_req_in, cisl_pkg::ADDR_CLEAR) ? reg_req_in.wdata : 16'h0000;

	always_comb begin
		next_s = s;
		// set wins over clear on every flag
		next_s.short_circuit_shutdown_flag = set_short
			| (s.short_circuit_shutdown_flag & ~clr[cisl_pkg::BIT_SHORT]); // R6 R13
		next_s.impedance_measure_flag = set_imp
			| (s.impedance_measure_flag & ~clr[cisl_pkg::BIT_IMPEDANCE]); // R7 R13
		next_s.key_release_flag = set_keyr | (s.key_release_flag & ~clr[cisl_pkg::BIT_KEY_REL]); // R8
		next_s.key_press_flag = set_keyp | (s.key_press_flag & ~clr[cisl_pkg::BIT_KEY_PRESS]); // R8
		next_s.clock_loss_flag = set_clk | (s.clock_loss_flag & ~clr[cisl_pkg::BIT_CLK_LOSS]); // R9
		next_s.mic_detect_flag = set_mic | (s.mic_detect_flag & ~clr[cisl_pkg::BIT_MIC]); // R10
		next_s.jack_insert_state = jack_next(s.jack_insert_state, set_ins, events_in.jack_eject,
			clr[cisl_pkg::BIT_JACK_INS_LO] | clr[cisl_pkg::BIT_JACK_INS_HI]); // R12 R14
		next_s.jack_eject_state = jack_next(s.jack_eject_state, set_ej, events_in.jack_insert,
			clr[cisl_pkg::BIT_JACK_EJ_LO] | clr[cisl_pkg::BIT_JACK_EJ_HI]); // R11 R15
		if (reg_hit(reg_req_in, cisl_pkg::ADDR_MASK)) begin
			next_s.mask = reg_req_in.wdata;
		end
		if (reg_hit(reg_req_in, cisl_pkg::ADDR_DISABLE)) begin
			next_s.disable_ctrl = reg_req_in.wdata;
		end
		if (reg_req_in.rd) begin
			case (reg_req_in.addr)
				cisl_pkg::ADDR_MASK: next_s.rdata = s.mask;
				cisl_pkg::ADDR_STATUS: next_s.rdata = status_word;
				cisl_pkg::ADDR_DISABLE: next_s.rdata = s.disable_ctrl;
				default: next_s.rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			s <= '0;
			s.mask <= cisl_pkg::MASK_RESET;
			s.disable_ctrl <= cisl_pkg::DISABLE_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign reg_rdata_out = s.rdata;

	cisl_irq_driver u_driver (
		.mclk_in(mclk_in),
		.sys_rst_in(sys_rst_in),
		.req_in(irq_req),
		.polarity_in(s.mask[cisl_pkg::BIT_LINE_POL]),
		.enable_in(s.mask[cisl_pkg::BIT_LINE_OE]),
		.line_out(irq_line_out),
		.line_oe_out(irq_line_oe_out)
	);

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (sys_rst_in);

	sequence keyp_pending_masked;
		s.key_press_flag && s.mask[cisl_pkg::BIT_KEY_PRESS];
	endsequence

	sequence ins_seen_then_eject;
		s.jack_insert_state == cisl_pkg::JACK_SEEN && events_in.jack_eject && !set_ins;
	endsequence

	sequence ej_seen_then_insert;
		s.jack_eject_state == cisl_pkg::JACK_SEEN && events_in.jack_insert && !set_ej;
	endsequence

	a_key_press_mask: assert property ( // R1
		keyp_pending_masked |-> live_bits[cisl_pkg::BIT_KEY_PRESS] == 1'b0)
		else $error("masked key press still reaches request");
	a_clock_loss_mask: assert property ( // R2
		s.clock_loss_flag && !s.disable_ctrl[cisl_pkg::BIT_CLK_LOSS]
		|-> live_bits[cisl_pkg::BIT_CLK_LOSS] == !s.mask[cisl_pkg::BIT_CLK_LOSS])
		else $error("clock loss mask not honoured");
	a_mic_mask_line: assert property ( // R3
		s.mic_detect_flag && !s.mask[cisl_pkg::BIT_MIC] && !s.disable_ctrl[cisl_pkg::BIT_MIC]
		&& s.mask[cisl_pkg::BIT_LINE_POL] |=> irq_line_out)
		else $error("unmasked mic detect did not raise line");
	a_jack_masks: assert property ( // R4
		s.mask[cisl_pkg::BIT_JACK_EJ_LO] && s.mask[cisl_pkg::BIT_JACK_INS_LO]
		|-> live_bits[3:0] == 4'h0)
		else $error("masked jack status reaches request");
	a_jack_insert_unmask: assert property ( // R5
		s.jack_insert_state != cisl_pkg::JACK_CLEAR && !s.mask[cisl_pkg::BIT_JACK_INS_LO]
		&& !s.disable_ctrl[cisl_pkg::BIT_JACK_INS_LO] |-> irq_req)
		else $error("unmasked jack insert did not request");
	a_short_set_wins: assert property ( // R6
		set_short && clr[cisl_pkg::BIT_SHORT] |=> s.short_circuit_shutdown_flag)
		else $error("short circuit event lost to a clear");
	a_impedance_clear: assert property ( // R7
		!set_imp && clr[cisl_pkg::BIT_IMPEDANCE] |=> !s.impedance_measure_flag)
		else $error("impedance flag not cleared");
	a_key_flags_apart: assert property ( // R8
		events_in.key_release && !events_in.key_press && !s.key_press_flag
		&& !s.disable_ctrl[cisl_pkg::BIT_KEY_REL] |=> s.key_release_flag && !s.key_press_flag)
		else $error("key release and press flags not separate");
	a_clock_loss_hold: assert property ( // R9
		s.clock_loss_flag && clr[cisl_pkg::BIT_CLK_LOSS] == 1'b0 |=> s.clock_loss_flag)
		else $error("clock loss flag dropped without clear");
	a_mic_status_read: assert property ( // R10
		reg_req_in.rd && reg_req_in.addr == cisl_pkg::ADDR_STATUS
		|=> reg_rdata_out[cisl_pkg::BIT_MIC] == $past(s.mic_detect_flag))
		else $error("mic flag not readable");
	a_eject_cancel: assert property ( // R11
		ej_seen_then_insert |=> s.jack_eject_state == cisl_pkg::JACK_CANCEL)
		else $error("eject not cancelled by insertion");
	a_insert_cancel: assert property ( // R12
		ins_seen_then_eject |=> s.jack_insert_state == cisl_pkg::JACK_CANCEL)
		else $error("insert not cancelled by removal");
	a_jack_never_three: assert property ( // R11
		s.jack_insert_state != 2'h3 && s.jack_eject_state != 2'h3)
		else $error("jack status reached undefined code");
	a_clear_zero_keeps: assert property ( // R13
		reg_hit(reg_req_in, cisl_pkg::ADDR_CLEAR) && reg_req_in.wdata == 16'h0000
		|=> ($past(status_word) & ~status_word & 16'h03f0) == 16'h0000)
		else $error("clear of zeros changed status");
	a_insert_clear: assert property ( // R14
		clr[1:0] != 2'h0 && !events_in.jack_insert && !events_in.jack_eject
		|=> s.jack_insert_state == cisl_pkg::JACK_CLEAR)
		else $error("insert status not cleared");
	a_eject_clear: assert property ( // R15
		clr[3:2] != 2'h0 && !events_in.jack_insert && !events_in.jack_eject
		|=> s.jack_eject_state == cisl_pkg::JACK_CLEAR)
		else $error("eject status not cleared");
	a_short_disable: assert property ( // R16
		s.disable_ctrl[cisl_pkg::BIT_SHORT] && !s.short_circuit_shutdown_flag
		|=> !s.short_circuit_shutdown_flag)
		else $error("disabled short circuit raised flag");
	a_impedance_disable: assert property ( // R17
		s.disable_ctrl[cisl_pkg::BIT_IMPEDANCE] && !s.impedance_measure_flag
		|=> !s.impedance_measure_flag)
		else $error("disabled impedance raised flag");
	a_line_idle: assert property ( // R20
		!irq_req && !s.mask[cisl_pkg::BIT_LINE_POL] |=> irq_line_out)
		else $error("active low line not idle high");
endmodule
`default_nettype wire

// ### rtl/cisl_pkg.sv
// constants and types for the codec interrupt status logic
// Summary of operation
// [R1] key-press mask 1 suppresses, 0 passes
// [R2] clock-loss mask 1 suppresses, 0 passes
// [R3] mic-detect mask 1 suppresses, 0 passes
// [R4] jack-eject mask 1 suppresses, 0 passes
// [R5] jack-insert mask 1 suppresses, 0 passes
// [R6] flag for short-circuit shutdown event
// [R7] flag for impedance measurement completion
// [R8] separate key release and key press flags
// [R9] flag for missing master clock
// [R10] flag for microphone or headset detected
// [R11] eject code: 00 clear, 01 seen, 10 cancelled
// [R12] insert code: 00 clear, 01 seen, 10 cancelled
// [R13] writing ones clears matching flags only
// [R14] clear bit 0 or 1 clears insert code
// [R15] clear bit 2 or 3 clears eject code
// [R16] short-circuit disable bit blocks its interrupt
// [R17] impedance disable bit blocks its interrupt
// [R18] line polarity: 1 active high, 0 low
// [R19] line driver enabled only while enable set
// [R20] line active while enabled unmasked flag pending
package cisl_pkg;
	localparam logic [7:0] ADDR_MASK = 8'h0f;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_CLEAR = 8'h11;
	localparam logic [7:0] ADDR_DISABLE = 8'h12;

	localparam int unsigned BIT_JACK_INS_LO = 0;
	localparam int unsigned BIT_JACK_INS_HI = 1;
	localparam int unsigned BIT_JACK_EJ_LO = 2;
	localparam int unsigned BIT_JACK_EJ_HI = 3;
	localparam int unsigned BIT_MIC = 4;
	localparam int unsigned BIT_CLK_LOSS = 5;
	localparam int unsigned BIT_KEY_PRESS = 6;
	localparam int unsigned BIT_KEY_REL = 7;
	localparam int unsigned BIT_IMPEDANCE = 8;
	localparam int unsigned BIT_SHORT = 9;
	localparam int unsigned BIT_LINE_OE = 11;
	localparam int unsigned BIT_LINE_POL = 15;

	localparam logic [15:0] MASK_RESET = 16'h0000;
	localparam logic [15:0] DISABLE_RESET = 16'hffff;
	localparam logic [15:0] SOURCE_BITS = 16'h03ff;

	localparam logic [1:0] JACK_CLEAR = 2'h0;
	localparam logic [1:0] JACK_SEEN = 2'h1;
	localparam logic [1:0] JACK_CANCEL = 2'h2;

	typedef struct packed {
		logic short_circuit;
		logic impedance;
		logic key_release;
		logic key_press;
		logic clock_loss;
		logic mic_detect;
		logic jack_eject;
		logic jack_insert;
	} cisl_evt_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [15:0] wdata;
	} cisl_reg_req_t;
endpackage

// ### tb/cisl_host.sv
// host model issuing register strobes to the codec interrupt block
`timescale 1ns/10ps
`default_nettype none
module cisl_host (
	input wire logic mclk_in,
	input wire logic [15:0] rdata_in,
	output var cisl_pkg::cisl_reg_req_t req_out
);
	initial begin
		req_out = '0;
	end
	// one-cycle strobe, released at the edge that takes it
	task automatic access(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk_in);
		req_out <= {w, ~w, a, d};
		@(posedge mclk_in);
		req_out <= '0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		access(1'b1, a, d);
	endtask
	task automatic clr(input logic [15:0] bits);
		access(1'b1, cisl_pkg::ADDR_CLEAR, bits);
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		access(1'b0, a, 16'h0000);
		@(posedge mclk_in);
		d = rdata_in;
	endtask
endmodule
`default_nettype wire

// ### tb/tb.sv
// self-checking bench for the codec interrupt status block
`timescale 1ns/10ps
`default_nettype none
module tb;
	typedef struct packed {
		logic [7:0] evt;
		logic [15:0] mask;
		logic [15:0] st;
		logic line;
	} cisl_row_t;
	localparam logic [7:0] A_MSK = cisl_pkg::ADDR_MASK;
	localparam logic [7:0] A_ST = cisl_pkg::ADDR_STATUS;
	localparam logic [7:0] A_DIS = cisl_pkg::ADDR_DISABLE;
	logic mclk_in;
	logic rst;
	cisl_pkg::cisl_evt_t evt;
	cisl_pkg::cisl_reg_req_t req;
	logic [15:0] rdata;
	logic line;
	logic line_oe;
	int failures = 0;
	int cmp_count = 0;
	int cycles = 0;
	cisl_row_t rows [13] = '{
		'{8'h01, 16'h0000, 16'h0001, 1'b1}, '{8'h02, 16'h0000, 16'h0004, 1'b1},
		'{8'h04, 16'h0000, 16'h0010, 1'b1}, '{8'h08, 16'h0000, 16'h0020, 1'b1},
		'{8'h10, 16'h0000, 16'h0040, 1'b1}, '{8'h20, 16'h0000, 16'h0080, 1'b1},
		'{8'h40, 16'h0000, 16'h0100, 1'b1}, '{8'h80, 16'h0000, 16'h0200, 1'b1},
		'{8'h01, 16'h0001, 16'h0001, 1'b0}, '{8'h02, 16'h0004, 16'h0004, 1'b0},
		'{8'h04, 16'h0010, 16'h0010, 1'b0}, '{8'h08, 16'h0020, 16'h0020, 1'b0},
		'{8'h10, 16'h0040, 16'h0040, 1'b0}
	};

	cisl_irq_status dut (
		.mclk_in(mclk_in),
		.sys_rst_in(rst),
		.events_in(evt),
		.reg_req_in(req),
		.reg_rdata_out(rdata),
		.irq_line_out(line),
		.irq_line_oe_out(line_oe)
	);
	cisl_host host (
		.mclk_in(mclk_in),
		.rdata_in(rdata),
		.req_out(req)
	);

	initial begin
		mclk_in = 1'b0;
		forever #2.5 mclk_in = ~mclk_in;
	end

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
		logic [15:0] v;
		host.rd(a, v);
		check(v, exp);
	endtask
	task automatic lchk(input logic oe, input logic l);
		check({14'h0000, line_oe, line}, {14'h0000, oe, l});
	endtask
	task automatic settle();
		repeat (3) @(posedge mclk_in);
	endtask
	task automatic pulse(input logic [7:0] e);
		@(posedge mclk_in);
		evt <= e;
		@(posedge mclk_in);
		evt <= '0;
		settle();
	endtask

	always @(posedge mclk_in) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			conclude();
		end
	end

	initial begin
		rst = 1'b1;
		evt = '0;
		repeat (4) @(posedge mclk_in);
		rst <= 1'b0;
		rchk(A_MSK, 16'h0000);
		rchk(A_DIS, 16'hffff);
		lchk(1'b0, 1'b1);
		pulse(8'hff);
		rchk(A_ST, 16'h0000);
		host.wr(A_DIS, 16'h0000);
		for (int i = 0; i < 13; i++) begin
			host.wr(A_MSK, 16'h8800 | rows[i].mask);
			pulse(rows[i].evt);
			rchk(A_ST, rows[i].st);
			lchk(1'b1, rows[i].line);
			host.clr(16'hffff);
			rchk(A_ST, 16'h0000);
			lchk(1'b1, 1'b0);
		end
		host.wr(A_MSK, 16'h8800);
		pulse(8'h30);
		host.clr(16'h0040);
		rchk(A_ST, 16'h0080);
		host.clr(16'h0080);
		pulse(8'h01);
		host.clr(16'h0002);
		rchk(A_ST, 16'h0000);
		pulse(8'h02);
		host.clr(16'h0008);
		rchk(A_ST, 16'h0000);
		pulse(8'h01);
		pulse(8'h02);
		rchk(A_ST, 16'h0006);
		host.clr(16'h0001);
		rchk(A_ST, 16'h0004);
		pulse(8'h01);
		rchk(A_ST, 16'h0009);
		host.clr(16'h0004);
		rchk(A_ST, 16'h0001);
		host.clr(16'h0001);
		// read-only and unmapped places
		host.wr(A_ST, 16'hffff);
		rchk(A_ST, 16'h0000);
		rchk(cisl_pkg::ADDR_CLEAR, 16'h0000);
		rchk(8'h20, 16'h0000);
		pulse(8'h10);
		host.wr(A_MSK, 16'h0800);
		settle();
		lchk(1'b1, 1'b0);
		host.wr(A_MSK, 16'h8800);
		settle();
		lchk(1'b1, 1'b1);
		host.wr(A_MSK, 16'h0000);
		settle();
		lchk(1'b0, 1'b0);
		host.clr(16'h0040);
		settle();
		lchk(1'b0, 1'b1);
		// cancel codes stay masked by the lower pair bit
		host.wr(A_MSK, 16'h8805);
		pulse(8'h01);
		pulse(8'h02);
		rchk(A_ST, 16'h0006);
		lchk(1'b1, 1'b0);
		host.clr(16'h000f);
		// event and clear in the same cycle
		fork
			pulse(8'h80);
			host.clr(16'h0200);
		join
		rchk(A_ST, 16'h0200);
		host.clr(16'h0000);
		rchk(A_ST, 16'h0200);
		settle();
		lchk(1'b1, 1'b1);
		// reset in mid-run
		rst <= 1'b1;
		repeat (4) @(posedge mclk_in);
		rst <= 1'b0;
		rchk(A_MSK, 16'h0000);
		rchk(A_DIS, 16'hffff);
		rchk(A_ST, 16'h0000);
		lchk(1'b0, 1'b1);
		conclude();
	end
endmodule
`default_nettype wire
